// ===== design/ias_pkg.sv
package ias_pkg;
    localparam int          NUM_IN        = 5;
    localparam int          NUM_OUT       = 2;
    localparam int          TEXT_MAX      = 63;
    localparam int          IMG_DEPTH     = 16;
    localparam logic [2:0]  IN_TYPEC      = 3'h0;
    localparam logic [2:0]  IN_WELCOME    = 3'h4;
    localparam logic [6:0]  PRIO_OFF      = 7'h00;
    localparam logic [6:0]  PRIO_MAX      = 7'h64;
    localparam logic [6:0]  PRIO_ANY      = 7'h65;
    localparam logic [6:0]  PRIO_PHYS_RST = 7'h32;
    localparam logic [6:0]  PRIO_WEL_RST  = 7'h64;
    localparam logic [1:0]  MODE_DIS      = 2'h0;
    localparam logic [1:0]  MODE_FIRST    = 2'h1;
    localparam logic [1:0]  MODE_LAST     = 2'h2;
    localparam logic [2:0]  LANES_TWO     = 3'h2;
    localparam logic [2:0]  LANES_FOUR    = 3'h4;
    localparam logic [23:0] GREY_PIXEL    = 24'hc0c0c0;
    localparam logic [23:0] BLACK_PIXEL   = 24'h000000;
    // register byte offsets
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_MANUAL    = 8'h04;
    localparam logic [7:0]  REG_STATUS    = 8'h08;
    localparam logic [7:0]  REG_TEXT      = 8'h0c;
    localparam logic [7:0]  REG_IMAGE     = 8'h10;
    localparam logic [1:0]  REG_PRIO_SEL  = 2'h1;
    // register field positions
    localparam int          CTRL_MODE0    = 0;
    localparam int          CTRL_MODE1    = 2;
    localparam int          CTRL_IMG_EN   = 4;
    localparam int          CTRL_USB_FOL  = 5;
    localparam int          CTRL_AUD_SRC  = 6;
    localparam int          CTRL_LANES4   = 9;
    localparam int          CTRL_FULL_BW  = 10;
    localparam int          CTRL_USB_MAN  = 11;
    localparam int          MAN_OUT_BIT   = 4;
    localparam int          TEXT_IDX      = 8;
    localparam int          IMG_START_BIT = 31;

    typedef logic [NUM_IN-1:0][6:0]  ias_prio_row_t;
    typedef logic [NUM_OUT-1:0][2:0] ias_sel_t;

    typedef struct packed {
        logic                          hready;
        logic [31:0]                   hrdata;
        logic                          wr_pend;
        logic [7:0]                    wr_addr;
        logic [NUM_OUT-1:0][1:0]       mode;
        logic                          image_en;
        logic                          usb_follow;
        logic                          lanes4;
        logic                          full_bw;
        logic [2:0]                    audio_src;
        logic [1:0]                    usb_manual;
        ias_sel_t                      sel;
        ias_prio_row_t [NUM_OUT-1:0]   prio;
        logic                          man_req;
        logic                          man_out;
        logic [2:0]                    man_in;
        logic [NUM_IN-1:0]             prev_act;
        logic                          prev_host;
        logic [TEXT_MAX-1:0][7:0]      text;
        logic [5:0]                    text_len;
        logic [IMG_DEPTH-1:0][23:0]    img;
        logic [4:0]                    img_cnt;
        logic                          hotplug_en;
        logic                          measure_en;
        logic                          audio_en;
        logic [NUM_IN-1:0]             audio_present;
        logic [1:0]                    usb_host;
        logic [2:0]                    lane_cnt;
        logic [23:0]                   pixel;
        logic [7:0]                    text_char;
        logic [23:0]                   text_color;
    } ias_state_t;
endpackage : ias_pkg

// ===== design/ias_autoselect.sv
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
//Contract
// - welcome generator is one extra selectable input beside physical inputs.
// - with image option off the generator shows a uniform light grey frame.
// - one image is stored; a new upload replaces the old one.
// - text up to 63 legal characters, drawn in black.
// - welcome source unavailable while first USB-C input is routed anywhere.
// - welcome routed blocks USB-C input one, its hotplug, measurement and audio.
// - welcome routed drops USB-C one analog audio, audio setting kept.
// - USB-C one activity is not sensed while welcome is shown.
// - host attach on USB-C one replaces welcome with that input.
// - alternate mode uses two or four lanes; full bandwidth means four.
// - policy per output is disabled, first detect or last detect.
// - priority 1 highest to 100 lowest, best active input wins.
// - with autoselect disabled only manual requests change the crosspoint; the code also lets host attach replace welcome then.
// - first detect keeps input until inactive or strictly better input active.
// - last detect takes newest input of equal or better priority.
// - a manual switch leaves the autoselect policy running.
// - each output has own priorities; any input may be disabled.
// - manual selection requests are accepted alongside autoselect.
// - follow-video USB routing tracks the chosen video host.
// - USB-C one audio-present reads false while welcome in use.
module ias_autoselect
    import ias_pkg::*;
(
    // clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                nrst_i,
    // ahb-lite slave
    input  wire logic                hsel_i,
    input  wire logic [31:0]         haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire logic [31:0]         hwdata_i,
    input  wire logic                hready_i,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    output logic [31:0]              hrdata_o,
    // sources
    input  wire logic [NUM_IN-2:0]   input_active_flag_i,
    input  wire logic                typec_host_i,
    input  wire logic [NUM_IN-1:0]   audio_present_i,
    input  wire logic [3:0]          pix_idx_i,
    input  wire logic [5:0]          text_idx_i,
    // crosspoint and gating
    output ias_sel_t                 video_sel_o,
    output logic                     typec_hotplug_en_o,
    output logic                     typec_measure_en_o,
    output logic                     analog_audio_en_o,
    output logic [NUM_IN-1:0]        audio_present_o,
    output logic [1:0]               usb_host_sel_o,
    output logic [2:0]               dp_lane_cnt_o,
    // welcome generator
    output logic [23:0]              welcome_pixel_o,
    output logic [7:0]               welcome_char_o,
    output logic [23:0]              welcome_text_color_o,
    output logic [5:0]               welcome_text_len_o
);

    ias_state_t    r;
    ias_state_t    next_r;
    logic          wel_any;
    logic          tc_any;
    logic          host_rise;
    logic [NUM_IN-1:0] act_raw;
    logic          cur_ok0;
    logic [6:0]    cur_p0;

    // best active input under a priority bound; ties keep the lower index
    function automatic logic [3:0] ias_pick(input ias_prio_row_t prio,
                                            input logic [NUM_IN-1:0] mask,
                                            input logic [6:0] limit,
                                            input logic incl_eq);
        logic [6:0] best;
        logic [6:0] p;
        logic       found;
        logic [2:0] idx;
        best  = PRIO_ANY;
        found = 1'b0;
        idx   = 3'h0;
        for (int i = 0; i < NUM_IN; i++) begin
            p = prio[i];
            if (mask[i] && p != PRIO_OFF && (p < limit || (incl_eq && p == limit))
                && p < best) begin
                best  = p;
                found = 1'b1;
                idx   = 3'(i);
            end
        end
        return {found, idx};
    endfunction : ias_pick

    function automatic logic ias_char_ok(input logic [7:0] c);
        return (c >= 8'h61 && c <= 8'h7a) || (c >= 8'h41 && c <= 8'h5a) ||
               (c >= 8'h30 && c <= 8'h39) || c == 8'h20 || c == 8'h2d ||
               c == 8'h5f || c == 8'h2e;
    endfunction : ias_char_ok

    always_comb begin
        wel_any = 1'b0;
        tc_any  = 1'b0;
        for (int k = 0; k < NUM_OUT; k++) begin
            wel_any = wel_any | (r.sel[k] == IN_WELCOME);
            tc_any  = tc_any | (r.sel[k] == IN_TYPEC);
        end
    end

    // welcome always carries a picture; typec flag blind while welcome shows
    assign act_raw   = {1'b1, input_active_flag_i[NUM_IN-2:1],
                        input_active_flag_i[0] & ~wel_any};
    assign host_rise = typec_host_i & ~r.prev_host;
    assign cur_p0    = r.prio[0][r.sel[0]];
    assign cur_ok0   = act_raw[r.sel[0]] && cur_p0 != PRIO_OFF;

    always_comb begin
        logic [NUM_IN-1:0] elig;
        logic [NUM_IN-1:0] act;
        logic [NUM_IN-1:0] rise;
        logic [3:0]        pk;
        logic [2:0]        cur;
        logic [6:0]        cur_p;
        logic              cur_ok;
        logic              tc_oth;
        logic              wel_oth;
        logic              wel_n;
        logic [7:0]        a;
        elig    = '1;
        act     = '0;
        pk      = '0;
        cur     = '0;
        cur_p   = '0;
        cur_ok  = 1'b0;
        tc_oth  = 1'b0;
        wel_oth = 1'b0;
        wel_n   = 1'b0;
        a       = haddr_i[7:0];
        rise    = act_raw & ~r.prev_act;
        next_r  = r;
        next_r.hready    = 1'b1;
        next_r.wr_pend   = 1'b0;
        next_r.man_req   = 1'b0;
        next_r.prev_act  = act_raw;
        next_r.prev_host = typec_host_i;

        // write data phase
        if (r.wr_pend) begin
            if (r.wr_addr == REG_CTRL) begin
                next_r.mode[0]    = hwdata_i[CTRL_MODE0 +: 2];
                next_r.mode[1]    = hwdata_i[CTRL_MODE1 +: 2];
                next_r.image_en   = hwdata_i[CTRL_IMG_EN];
                next_r.usb_follow = hwdata_i[CTRL_USB_FOL];
                next_r.audio_src  = hwdata_i[CTRL_AUD_SRC +: 3];
                next_r.lanes4     = hwdata_i[CTRL_LANES4];
                next_r.full_bw    = hwdata_i[CTRL_FULL_BW];
                next_r.usb_manual = hwdata_i[CTRL_USB_MAN +: 2];
            end else if (r.wr_addr == REG_MANUAL) begin
                next_r.man_req = 1'b1;
                next_r.man_out = hwdata_i[MAN_OUT_BIT];
                next_r.man_in  = hwdata_i[2:0];
            end else if (r.wr_addr == REG_TEXT) begin
                if (ias_char_ok(hwdata_i[7:0])
                    && hwdata_i[TEXT_IDX +: 6] < 6'(TEXT_MAX)) begin
                    next_r.text[hwdata_i[TEXT_IDX +: 6]] = hwdata_i[7:0];
                    next_r.text_len = hwdata_i[TEXT_IDX +: 6] + 6'h01;
                end
            end else if (r.wr_addr == REG_IMAGE) begin
                if (hwdata_i[IMG_START_BIT]) begin
                    next_r.img[0]  = hwdata_i[23:0];
                    next_r.img_cnt = 5'h01;
                end else if (r.img_cnt < 5'(IMG_DEPTH)) begin
                    next_r.img[r.img_cnt[3:0]] = hwdata_i[23:0];
                    next_r.img_cnt = r.img_cnt + 5'h01;
                end
            end else if (r.wr_addr[7:6] == REG_PRIO_SEL && r.wr_addr[4:2] < 3'(NUM_IN)) begin
                if (hwdata_i[6:0] <= PRIO_MAX) begin
                    next_r.prio[r.wr_addr[5]][r.wr_addr[4:2]] = hwdata_i[6:0];
                end
            end
        end

        // address phase; zero wait states, read data from a flop
        if (hsel_i && htrans_i[1] && hready_i) begin
            next_r.wr_pend = hwrite_i;
            next_r.wr_addr = a;
            if (!hwrite_i) begin
                next_r.hrdata = '0;
                if (a == REG_CTRL) begin
                    next_r.hrdata = {19'h0, r.usb_manual, r.full_bw, r.lanes4, r.audio_src,
                                     r.usb_follow, r.image_en, r.mode[1], r.mode[0]};
                end else if (a == REG_STATUS) begin
                    next_r.hrdata = {3'h0, r.img_cnt, 3'h0, act_raw, 6'h0, tc_any, wel_any,
                                     1'b0, r.sel[1], 1'b0, r.sel[0]};
                end else if (a == REG_TEXT) begin
                    next_r.hrdata = {26'h0, r.text_len};
                end else if (a == REG_IMAGE) begin
                    next_r.hrdata = {27'h0, r.img_cnt};
                end else if (a[7:6] == REG_PRIO_SEL && a[4:2] < 3'(NUM_IN)) begin
                    next_r.hrdata = {25'h0, r.prio[a[5]][a[4:2]]};
                end
            end
        end

        // selection, output by output; later outputs see earlier decisions
        for (int o = 0; o < NUM_OUT; o++) begin
            tc_oth  = 1'b0;
            wel_oth = 1'b0;
            for (int k = 0; k < NUM_OUT; k++) begin
                if (k != o) begin
                    tc_oth  = tc_oth | (next_r.sel[k] == IN_TYPEC);
                    wel_oth = wel_oth | (next_r.sel[k] == IN_WELCOME);
                end
            end
            elig = '1;
            if (tc_oth) begin
                elig[IN_WELCOME] = 1'b0;
            end
            if (wel_oth) begin
                elig[IN_TYPEC] = 1'b0;
            end
            act    = act_raw & elig;
            cur    = next_r.sel[o];
            cur_p  = r.prio[o][cur];
            cur_ok = act[cur] && cur_p != PRIO_OFF;
            pk     = '0;
            if (host_rise && cur == IN_WELCOME) begin
                next_r.sel[o] = IN_TYPEC;
            end else if (r.man_req && 32'(r.man_out) == o) begin
                // manual pick keeps the policy in place
                if (r.man_in < 3'(NUM_IN) && !(r.man_in == IN_WELCOME && tc_oth)
                    && !(r.man_in == IN_TYPEC && wel_oth)) begin
                    next_r.sel[o] = r.man_in;
                end
            end else begin
                unique case (r.mode[o])
                    MODE_FIRST: begin
                        pk = cur_ok ? ias_pick(r.prio[o], act, cur_p, 1'b0)
                                    : ias_pick(r.prio[o], act, PRIO_ANY, 1'b0);
                    end
                    MODE_LAST: begin
                        pk = cur_ok ? ias_pick(r.prio[o], act & rise, cur_p, 1'b1)
                                    : ias_pick(r.prio[o], act, PRIO_ANY, 1'b0);
                    end
                    default: pk = '0;
                endcase
                if (pk[3]) begin
                    next_r.sel[o] = pk[2:0];
                end
            end
        end

        for (int k = 0; k < NUM_OUT; k++) begin
            wel_n = wel_n | (next_r.sel[k] == IN_WELCOME);
        end
        next_r.hotplug_en = ~wel_n;
        next_r.measure_en = ~wel_n;
        // audio routing field stays as written; only the path is cut
        // use the source being written this cycle, else a fresh write leaks one cycle
        next_r.audio_en = !(next_r.audio_src == IN_TYPEC && wel_n);
        next_r.audio_present = audio_present_i;
        if (wel_n) begin
            next_r.audio_present[IN_TYPEC] = 1'b0;
        end
        if (!r.usb_follow) begin
            next_r.usb_host = r.usb_manual;
        end else if (next_r.sel[0] != IN_WELCOME) begin
            next_r.usb_host = next_r.sel[0][1:0];
        end
        next_r.lane_cnt = (r.lanes4 || r.full_bw) ? LANES_FOUR : LANES_TWO;
        // no uploaded image falls back to the grey frame as well
        next_r.pixel = (r.image_en && r.img_cnt != 5'h00) ? r.img[pix_idx_i]
                                                          : GREY_PIXEL;
        next_r.text_char  = (text_idx_i < r.text_len) ? r.text[text_idx_i] : 8'h00;
        next_r.text_color = BLACK_PIXEL;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r            <= '0;
            r.hready     <= 1'b1;
            r.sel        <= {NUM_OUT{IN_WELCOME}};
            r.prio       <= {NUM_OUT{PRIO_WEL_RST, {(NUM_IN-1){PRIO_PHYS_RST}}}};
            r.lanes4     <= 1'b1;
            r.audio_src  <= IN_TYPEC;
            r.lane_cnt   <= LANES_FOUR;
            r.pixel      <= GREY_PIXEL;
        end else begin
            r <= next_r;
        end
    end

    assign hreadyout_o          = r.hready;
    assign hresp_o              = 1'b0;
    assign hrdata_o             = r.hrdata;
    assign video_sel_o          = r.sel;
    assign typec_hotplug_en_o   = r.hotplug_en;
    assign typec_measure_en_o   = r.measure_en;
    assign analog_audio_en_o    = r.audio_en;
    assign audio_present_o      = r.audio_present;
    assign usb_host_sel_o       = r.usb_host;
    assign dp_lane_cnt_o        = r.lane_cnt;
    assign welcome_pixel_o      = r.pixel;
    assign welcome_char_o       = r.text_char;
    assign welcome_text_color_o = r.text_color;
    assign welcome_text_len_o   = r.text_len;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    a_excl_routes: assert property (!(wel_any && tc_any))
        else $error("welcome and usb-c one routed together");
    a_hotplug_gate: assert property (wel_any |-> !typec_hotplug_en_o && !typec_measure_en_o)
        else $error("usb-c one hotplug or measure live under welcome");
    a_audio_drop: assert property ((r.audio_src == IN_TYPEC && wel_any)
                                   |-> !analog_audio_en_o && !audio_present_o[0])
        else $error("usb-c one audio passes under welcome");
    a_host_switch: assert property ((host_rise && r.sel[0] == IN_WELCOME)
                                    |=> r.sel[0] == IN_TYPEC)
        else $error("host attach did not replace welcome");
    a_lane_count: assert property (r.full_bw |=> dp_lane_cnt_o == LANES_FOUR
                                   && $past(r.full_bw))
        else $error("full bandwidth without four lanes");
    a_prio_bound: assert property (r.prio[0][0] <= PRIO_MAX && r.prio[1][4] <= PRIO_MAX)
        else $error("priority above lowest level");
    a_disabled_hold: assert property ((r.mode[0] == MODE_DIS && !r.man_req && !host_rise)
                                      |=> $stable(r.sel[0]))
        else $error("disabled output changed without request");
    a_first_keep: assert property ((r.mode[0] == MODE_FIRST && cur_ok0 && !r.man_req && !host_rise)
                                   |=> $stable(r.sel[0]) || r.prio[0][r.sel[0]] < $past(cur_p0))
        else $error("first detect left a live input");
    a_last_take: assert property ((r.mode[0] == MODE_LAST && cur_ok0 && !r.man_req && !host_rise)
                                  |=> $stable(r.sel[0]) || r.prio[0][r.sel[0]] <= $past(cur_p0))
        else $error("last detect took a worse input");
    a_grey_frame: assert property (!r.image_en |=> welcome_pixel_o == GREY_PIXEL)
        else $error("grey frame missing with image off");
    a_text_len: assert property (r.text_len <= 6'(TEXT_MAX) && welcome_text_color_o == BLACK_PIXEL)
        else $error("text too long or not black");

    // the usb routing output trails the usb_follow setting by one flop; the sense mask acts in the same cycle
    a_usb_follow: assert property (($past(r.usb_follow) && r.sel[0] != IN_WELCOME)
                                   |-> usb_host_sel_o == r.sel[0][1:0])
        else $error("usb host not following video");
    a_sense_mask: assert property (wel_any |-> !act_raw[IN_TYPEC])
        else $error("usb-c one activity sensed under welcome");

    // welcome content checks
    a_text_char: assert property ($past(r.text_len) == 6'h00 |-> welcome_char_o == 8'h00)
        else $error("character shown with empty text");
    a_grey_noimg: assert property ($past(r.img_cnt) == 5'h00 |-> welcome_pixel_o == GREY_PIXEL)
        else $error("pixel shown without stored image");
    a_img_bound: assert property (r.img_cnt <= 5'(IMG_DEPTH))
        else $error("image store overrun");

    // two lanes only when neither four lanes nor full bandwidth was asked
    a_lane_two: assert property ((!$past(r.lanes4) && !$past(r.full_bw))
                                 |-> dp_lane_cnt_o == LANES_TWO)
        else $error("lane count not two");

    // the policy checks watch out0 only; out1 runs the same loop body
    // limitation: a priority rewrite in the same cycle may move the pick
    c_audio_cut: cover property (wel_any && r.audio_src == IN_TYPEC && !analog_audio_en_o);

    c_host_attach: cover property (host_rise && r.sel[0] == IN_WELCOME ##1 r.sel[0] == IN_TYPEC);
    c_first_move: cover property (r.mode[0] == MODE_FIRST ##1 !$stable(r.sel[0]));
    c_last_move: cover property (r.mode[1] == MODE_LAST ##1 !$stable(r.sel[1]));
    c_manual_take: cover property (r.man_req ##1 !$stable(r.sel));

endmodule : ias_autoselect

// ===== testbench/ias_src_model.sv
`timescale 1ns/1ps
module ias_src_model (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    // scenario requests
    input  wire logic [3:0] want_act_i,
    input  wire logic       want_host_i,
    // toward the block
    output logic [3:0]      act_o,
    output logic            host_o
);
    // detectors settle just after an edge, never mid-cycle
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            act_o  <= 4'h0;
            host_o <= 1'b0;
        end else begin
            act_o  <= want_act_i;
            host_o <= want_host_i;
        end
    end
endmodule : ias_src_model

// ===== testbench/ias_autoselect_tb.sv
`timescale 1ns/1ps
module ias_autoselect_tb;
    import ias_pkg::*;
    logic        sys_clk_i, nrst_i, hsel, hwrite, hrdy, hresp, hotplug, host, want_host;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [3:0]  want_act, act;
    logic [4:0]  aud_pres;
    logic [2:0]  lanes;
    logic        aud_en, meas;
    logic [7:0]  chr;
    logic [1:0]  usb;
    logic [23:0] pix;
    ias_sel_t    sel;
    int          n_fail, num_checks;

    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    ias_src_model SRC (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .want_act_i(want_act),
        .want_host_i(want_host), .act_o(act), .host_o(host));

    ias_autoselect DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp),
        .hrdata_o(hrdata), .input_active_flag_i(act), .typec_host_i(host),
        .audio_present_i(5'h1f), .pix_idx_i(4'h0), .text_idx_i(6'h00),
        .video_sel_o(sel), .typec_hotplug_en_o(hotplug), .typec_measure_en_o(meas),
        .analog_audio_en_o(aud_en), .audio_present_o(aud_pres), .usb_host_sel_o(usb),
        .dp_lane_cnt_o(lanes), .welcome_pixel_o(pix), .welcome_char_o(chr),
        .welcome_text_color_o(), .welcome_text_len_o());

    task final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask : chk

    // bounded: a slave that never answers ends the run
    task wait_rdy;
        int i;
        i = 0;
        @(posedge sys_clk_i);
        while (hrdy !== 1'b1 && i < 50) begin
            @(posedge sys_clk_i);
            i++;
        end
        if (i == 50) begin
            n_fail++;
            final_report;
        end
    endtask : wait_rdy

    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask : ahb

    // outputs follow one cycle after the sources, plus the model's own stage
    task settle;
        repeat (4) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask : settle

    initial begin
        nrst_i = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        want_act = 4'h0;
        want_host = 1'b0;
        n_fail = 0;
        num_checks = 0;
        repeat (16) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        settle;
        chk("sel0", 32'(IN_WELCOME), 32'(sel[0]));
        chk("hotplug", 32'h0, 32'(hotplug));
        chk("aud_pres", 32'h1e, 32'(aud_pres));
        chk("pixel", 32'(GREY_PIXEL), 32'(pix));
        chk("lanes", 32'(LANES_FOUR), 32'(lanes));
        @(posedge sys_clk_i);
        ahb(1'b0, 32'h44, 32'h0); chk("prio", 32'(PRIO_PHYS_RST), rd);
        ahb(1'b0, 32'h30, 32'h0); chk("unmapped", 32'h0, rd);
        $display("test reset done");
        ahb(1'b1, 32'h0, 32'h201);
        want_act <= 4'h4; settle; chk("sel0", 32'h2, 32'(sel[0]));
        want_act <= 4'h6; settle; chk("sel0", 32'h2, 32'(sel[0]));
        want_act <= 4'h2; settle; chk("sel0", 32'h1, 32'(sel[0]));
        $display("test first detect done");
        @(posedge sys_clk_i);
        ahb(1'b1, 32'h0, 32'h202);
        want_act <= 4'ha; settle; chk("sel0", 32'h3, 32'(sel[0]));
        @(posedge sys_clk_i);
        ahb(1'b1, 32'h4, 32'h1); settle; chk("sel0", 32'h1, 32'(sel[0]));
        @(posedge sys_clk_i);
        ahb(1'b1, 32'h48, 32'h0);
        want_act <= 4'he; settle; chk("sel0", 32'h1, 32'(sel[0]));
        want_act <= 4'hc; settle; chk("sel0", 32'h3, 32'(sel[0]));
        $display("test last detect done");
        @(posedge sys_clk_i);
        ahb(1'b1, 32'h0, 32'h200);
        ahb(1'b1, 32'h4, 32'h10); settle; chk("sel1", 32'h0, 32'(sel[1]));
        chk("hotplug", 32'h1, 32'(hotplug));
        @(posedge sys_clk_i);
        ahb(1'b1, 32'h4, 32'h4); settle; chk("sel0", 32'h3, 32'(sel[0]));
        @(posedge sys_clk_i);
        ahb(1'b1, 32'h4, 32'h14); settle; chk("sel1", 32'h4, 32'(sel[1]));
        chk("hotplug", 32'h0, 32'(hotplug));
        chk("aud_en", 32'h0, 32'(aud_en));
        chk("aud_pres", 32'h1e, 32'(aud_pres));
        want_host <= 1'b1; settle; chk("sel1", 32'h0, 32'(sel[1]));
        chk("measure", 32'h1, 32'(meas));
        chk("aud_en", 32'h1, 32'(aud_en));
        want_act <= 4'h2; settle; chk("sel0", 32'h3, 32'(sel[0]));
        $display("test manual and welcome done");
        @(posedge sys_clk_i);
        ahb(1'b1, 32'hc, 32'h41);
        ahb(1'b1, 32'hc, 32'h121);
        ahb(1'b0, 32'hc, 32'h0); chk("text_len", 32'h1, rd);
        ahb(1'b1, 32'h10, 32'h80abcdef);
        ahb(1'b1, 32'h0, 32'h30);
        settle;
        chk("pixel", 32'habcdef, 32'(pix));
        chk("char", 32'h41, 32'(chr));
        chk("usb", 32'h3, 32'(usb));
        chk("lanes", 32'(LANES_TWO), 32'(lanes));
        chk("hresp", 32'h0, 32'(hresp));
        $display("test welcome content done");
        final_report;
    end
endmodule : ias_autoselect_tb
